// ---- hdl/fpd_defines.svh ----
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH
`define FPD_CP_DATA      4'h1
`define FPD_CP_MULTI     4'h2
`define FPD_DATA_CLASS   4'he
`define FPD_MULTI_CLASS  3'h6
`define FPD_WORD_BYTES   32'h0000_0004
`define FPD_REG_LAST     3'h7
`endif

// ---- hdl/fpd_pkg.sv ----
package fpd_pkg;
    typedef enum logic [4:0] {
        FPD_ADD   = 5'h00, FPD_MUL   = 5'h02, FPD_SUB   = 5'h04, FPD_RSUB  = 5'h06,
        FPD_DIV   = 5'h08, FPD_RDIV  = 5'h0a, FPD_REM   = 5'h10, FPD_QMUL  = 5'h12,
        FPD_QDIV  = 5'h14, FPD_QRDIV = 5'h16, FPD_MOVE  = 5'h01, FPD_MOVN  = 5'h03,
        FPD_MAG   = 5'h05, FPD_RND   = 5'h07, FPD_SQRT  = 5'h09, FPD_URND  = 5'h1d,
        FPD_NORM  = 5'h1f
    } fpd_op_t;
    typedef enum logic [1:0] {
        FPD_SINGLE = 2'h0, FPD_DOUBLE = 2'h1, FPD_EXTENDED = 2'h2, FPD_BADPREC = 2'h3
    } fpd_prec_t;
    typedef enum logic [1:0] {
        FPD_NEAREST = 2'h0, FPD_PLUS_INF = 2'h1, FPD_MINUS_INF = 2'h2, FPD_ZERO = 2'h3
    } fpd_round_t;
endpackage : fpd_pkg

// ---- hdl/fpd_dec_if.sv ----
`timescale 1ns/10ps
interface fpd_dec_if;
    logic [31:0]        insn;
    logic               data_hit;
    logic               multi_hit;
    logic [4:0]         opcode;
    logic               legal_op;
    modport decoder (input insn, output data_hit, multi_hit, opcode, legal_op);
    modport user    (output insn, input data_hit, multi_hit, opcode, legal_op);
endinterface : fpd_dec_if

// ---- hdl/fpd_classify.sv ----
`timescale 1ns/10ps
`include "fpd_defines.svh"
module fpd_classify (
    fpd_dec_if.decoder dec
);
    logic [4:0] op;
    assign op = {dec.insn[23:20], dec.insn[15]};
    assign dec.opcode = op;
    assign dec.data_hit = (dec.insn[27:24] == `FPD_DATA_CLASS) && !dec.insn[4]
                       && (dec.insn[11:8] == `FPD_CP_DATA);
    assign dec.multi_hit = (dec.insn[27:25] == `FPD_MULTI_CLASS)
                        && (dec.insn[11:8] == `FPD_CP_MULTI);
    always_comb begin
        unique case (op)
            5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h10,
            5'h12, 5'h14, 5'h16,
            5'h01, 5'h03, 5'h05, 5'h07, 5'h09,
            5'h1d, 5'h1f: dec.legal_op = 1'b1;
            default:      dec.legal_op = 1'b0;
        endcase
    end
endmodule : fpd_classify

// ---- hdl/fpd_decoder.sv ----
`timescale 1ns/10ps
`include "fpd_defines.svh"
module fpd_decoder (
    input  wire logic                i_clk_sys,
    input  wire logic                i_resetn,
    input  wire logic                i_valid,
    input  wire logic [31:0]         i_insn,
    input  wire logic                i_cond_pass,
    input  wire logic [31:0]         i_base_value,
    output logic                     o_done,
    output logic                     o_undef_trap,
    output logic                     o_data_op,
    output fpd_pkg::fpd_op_t         o_opcode,
    output fpd_pkg::fpd_prec_t       o_dest_precision,
    output fpd_pkg::fpd_round_t      o_rounding_mode,
    output logic [2:0]               o_dest_reg,
    output logic [2:0]               o_first_operand_reg,
    output logic [2:0]               o_second_operand_reg,
    output logic                     o_const_valid,
    output logic [31:0]              o_const_value,
    output logic                     o_mem_req,
    output logic                     o_mem_load,
    output logic [31:0]              o_mem_addr,
    output logic [2:0]               o_mem_reg,
    output logic                     o_base_wr,
    output logic [3:0]               o_base_reg,
    output logic [31:0]              o_base_wdata
);
    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    fpd_dec_if dec();
    assign dec.insn = i_insn;
    fpd_classify u_classify (
        .dec (dec)
    );
    typedef enum logic [2:0] {
        FPD_IDLE = 3'b001, FPD_XFER = 3'b010, FPD_WB = 3'b100
    } fpd_state_t;
    fpd_state_t  state, next_state;
    logic [3:0]  words, next_words;
    logic [1:0]  wsub, next_wsub;
    logic [31:0] addr, next_addr;
    logic [31:0] wbval, next_wbval;
    logic [2:0]  reg_idx, next_reg_idx;
    logic        is_load, next_is_load;
    logic        wb, next_wb;
    logic [3:0]  breg, next_breg;
    logic        done, next_done, trap, next_trap, dop, next_dop;
    logic [4:0]  opc, next_opc;
    logic [1:0]  prec, next_prec, rnd, next_rnd;
    logic [2:0]  fd, next_fd, fn, next_fn, fm, next_fm;
    logic        cv, next_cv;
    logic [31:0] cval, next_cval;
    logic        mreq, next_mreq;
    logic        bwr, next_bwr;
    logic [31:0] offset;
    logic [31:0] moved;
    logic [2:0]  count;
    function automatic logic [31:0] const_of(input logic [2:0] sel);
        // Single-precision bit patterns; wider formats are built downstream
        unique case (sel)
            3'h0:    const_of = 32'h0000_0000;
            3'h1:    const_of = 32'h3f80_0000;
            3'h2:    const_of = 32'h4000_0000;
            3'h3:    const_of = 32'h4040_0000;
            3'h4:    const_of = 32'h4080_0000;
            3'h5:    const_of = 32'h40a0_0000;
            3'h6:    const_of = 32'h3f00_0000;
            default: const_of = 32'h4120_0000;
        endcase
    endfunction : const_of
    // Count bits 22,15: 00 means four
    assign count = {~i_insn[22] & ~i_insn[15], i_insn[22], i_insn[15]};
    assign offset = {22'h00_0000, i_insn[7:0], 2'h0};
    // U (bit 23)=1 adds the word offset to the base, U=0 subtracts it
    assign moved = i_insn[23] ? i_base_value + offset : i_base_value - offset;
    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state; next_words = words; next_wsub = wsub; next_addr = addr;
        next_wbval = wbval; next_reg_idx = reg_idx; next_is_load = is_load; next_wb = wb;
        next_breg = breg; next_done = 1'b0; next_trap = 1'b0; next_dop = 1'b0;
        next_opc = opc; next_prec = prec; next_rnd = rnd; next_fd = fd; next_fn = fn;
        next_fm = fm; next_cv = cv; next_cval = cval; next_mreq = 1'b0; next_bwr = 1'b0;
        unique case (state)
            FPD_IDLE: begin
                if (i_valid && !i_cond_pass) begin
                    next_done = 1'b1;
                end else if (i_valid && dec.data_hit) begin
                    next_opc  = dec.opcode;
                    next_prec = {i_insn[19], i_insn[7]};
                    next_rnd  = i_insn[6:5];
                    next_fd   = i_insn[14:12];
                    next_fn   = i_insn[18:16];
                    next_fm   = i_insn[2:0];
                    next_cv   = i_insn[3];
                    next_cval = const_of(i_insn[2:0]);
                    next_trap = !dec.legal_op || ({i_insn[19], i_insn[7]} == 2'h3);
                    next_dop  = !next_trap;
                    next_done = 1'b1;
                end else if (i_valid && dec.multi_hit) begin
                    next_is_load = i_insn[20];
                    next_wb      = i_insn[21];
                    next_breg    = i_insn[19:16];
                    next_reg_idx = i_insn[14:12];
                    next_words   = {1'b0, count} * 4'h3;
                    next_wsub    = 2'h0;
                    next_wbval   = moved;
                    // Transfers climb upward; a down-stack starts at base minus offset
                    next_addr    = (i_insn[24] || !i_insn[23]) ? moved : i_base_value;
                    next_state   = FPD_XFER;
                end else if (i_valid) begin
                    next_trap = 1'b1;
                    next_done = 1'b1;
                end
            end
            FPD_XFER: begin
                // Three opaque words per register keep an unnormalized round result exact
                next_mreq  = 1'b1;
                next_addr  = addr + `FPD_WORD_BYTES;
                next_words = words - 4'h1;
                next_wsub  = (wsub == 2'h2) ? 2'h0 : wsub + 2'h1;
                if (wsub == 2'h2) begin
                    next_reg_idx = reg_idx + 3'h1;
                end
                if (words == 4'h1) begin
                    next_state = FPD_WB;
                end
            end
            FPD_WB: begin
                next_bwr   = wb;
                next_done  = 1'b1;
                next_state = FPD_IDLE;
            end
            default: next_state = FPD_IDLE;
        endcase
    end
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            state <= FPD_IDLE; words <= 4'h0; wsub <= 2'h0; addr <= 32'h0000_0000;
            wbval <= 32'h0000_0000; reg_idx <= 3'h0; is_load <= 1'b0; wb <= 1'b0;
            breg <= 4'h0; done <= 1'b0; trap <= 1'b0; dop <= 1'b0; opc <= 5'h00;
            prec <= 2'h0; rnd <= 2'h0; fd <= 3'h0; fn <= 3'h0; fm <= 3'h0; cv <= 1'b0;
            cval <= 32'h0000_0000; mreq <= 1'b0; bwr <= 1'b0;
            o_mem_addr <= 32'h0000_0000; o_mem_reg <= 3'h0;
        end else begin
            state <= next_state; words <= next_words; wsub <= next_wsub; addr <= next_addr;
            wbval <= next_wbval; reg_idx <= next_reg_idx; is_load <= next_is_load;
            wb <= next_wb; breg <= next_breg; done <= next_done; trap <= next_trap;
            dop <= next_dop; opc <= next_opc; prec <= next_prec; rnd <= next_rnd;
            fd <= next_fd; fn <= next_fn; fm <= next_fm; cv <= next_cv; cval <= next_cval;
            mreq <= next_mreq; bwr <= next_bwr;
            o_mem_addr <= addr; o_mem_reg <= reg_idx;
        end
    end
    assign o_done = done;
    assign o_undef_trap = trap;
    assign o_data_op = dop;
    assign o_opcode = fpd_pkg::fpd_op_t'(opc);
    assign o_dest_precision = fpd_pkg::fpd_prec_t'(prec);
    assign o_rounding_mode = fpd_pkg::fpd_round_t'(rnd);
    assign o_dest_reg = fd;
    assign o_first_operand_reg = fn;
    assign o_second_operand_reg = fm;
    assign o_const_valid = cv;
    assign o_const_value = cval;
    assign o_mem_req = mreq;
    assign o_mem_load = is_load;
    assign o_base_wr = bwr;
    assign o_base_reg = breg;
    assign o_base_wdata = wbval;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_cond_fail_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && !i_cond_pass |=> !o_data_op && !o_undef_trap && !o_mem_req)
        else $error("failed condition had side effects");
    a_prec_trap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && i_cond_pass && dec.data_hit && i_insn[19] && i_insn[7]
        |=> o_undef_trap)
        else $error("precision 11 did not trap");
    a_reserved_trap: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && i_cond_pass && dec.data_hit
        && {i_insn[23:20], i_insn[15]} == 5'h1a |=> o_undef_trap)
        else $error("reserved opcode did not trap");
    a_add_legal: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && i_cond_pass && dec.data_hit && !i_insn[19]
        && {i_insn[23:20], i_insn[15]} == 5'h00 |=> o_data_op && o_opcode == fpd_pkg::FPD_ADD)
        else $error("add not decoded");
    a_const_one: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && i_cond_pass && dec.data_hit && i_insn[3:0] == 4'h9
        |=> o_const_valid && o_const_value == 32'h3f80_0000)
        else $error("constant 1.0 wrong");
    a_addr_step: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_mem_req ##1 o_mem_req |-> o_mem_addr == $past(o_mem_addr) + 32'h0000_0004)
        else $error("address step not one word");
    a_wb_follows: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        o_base_wr |-> o_done && $past(wb))
        else $error("base written without write-back bit");
    a_one_reg_words: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
        state == FPD_IDLE && i_valid && i_cond_pass && dec.multi_hit && !i_insn[22] && i_insn[15]
        |=> ##1 o_mem_req [*3] ##1 !o_mem_req)
        else $error("one register did not move three words");
    c_data_op: cover property (@(posedge i_clk_sys) o_data_op);
    c_trap: cover property (@(posedge i_clk_sys) o_undef_trap);
    c_base_wr: cover property (@(posedge i_clk_sys) o_base_wr);
endmodule : fpd_decoder

// ---- test/fpd_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Host register file feeding the base value and taking write-backs
// ----------------------------------------------------------------------
module fpd_host_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic [3:0]  i_read_reg,
    input  wire logic        i_base_wr,
    input  wire logic [3:0]  i_base_reg,
    input  wire logic [31:0] i_base_wdata,
    output logic      [31:0] o_base_value
);
    logic [31:0] regs      [16];
    logic [31:0] next_regs [16];

    // Updated base lands at the edge that ends the write pulse
    always_comb begin
        next_regs = regs;
        if (i_base_wr) begin
            next_regs[i_base_reg] = i_base_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            for (int k = 0; k < 16; k++) begin
                regs[k] <= 32'h0000_1000 + 32'(k) * 32'h0000_0100;
            end
        end else begin
            regs <= next_regs;
        end
    end

    assign o_base_value = regs[i_read_reg];
endmodule : fpd_host_model

// ---- test/fpd_decoder_tb_top.sv ----
`timescale 1ns/10ps
module fpd_decoder_tb_top;
    logic                 i_clk_sys, i_resetn, i_valid, i_cond_pass;
    logic [31:0]          i_insn, i_base_value;
    logic                 o_done, o_undef_trap, o_data_op, o_const_valid;
    fpd_pkg::fpd_op_t     o_opcode;
    fpd_pkg::fpd_prec_t   o_dest_precision;
    fpd_pkg::fpd_round_t  o_rounding_mode;
    logic [2:0]           o_dest_reg, o_first_operand_reg, o_second_operand_reg, o_mem_reg;
    logic [31:0]          o_const_value, o_mem_addr, o_base_wdata;
    logic                 o_mem_req, o_mem_load, o_base_wr;
    logic [3:0]           o_base_reg;
    int                   mismatches, check_count, nw;
    logic [31:0]          wa [16];
    logic [2:0]           wr [16];
    logic                 wl [16];
    logic                 trp, dop, bwr;
    logic [31:0]          bdat;
    logic [3:0]           breg;
    logic [31:0]          base_m [16];
    logic [31:0]          kval [8] = '{32'h0000_0000, 32'h3f80_0000, 32'h4000_0000,
        32'h4040_0000, 32'h4080_0000, 32'h40a0_0000, 32'h3f00_0000, 32'h4120_0000};
    logic [4:0]           good [17] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h10,
        5'h12, 5'h14, 5'h16, 5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h1d, 5'h1f};
    logic [4:0]           bad [15] = '{5'h0c, 5'h0e, 5'h18, 5'h1a, 5'h1c, 5'h1e, 5'h0b,
        5'h0d, 5'h0f, 5'h11, 5'h13, 5'h15, 5'h17, 5'h19, 5'h1b};

    fpd_decoder i_dut (.i_clk_sys, .i_resetn, .i_valid, .i_insn, .i_cond_pass, .i_base_value,
        .o_done, .o_undef_trap, .o_data_op, .o_opcode, .o_dest_precision, .o_rounding_mode,
        .o_dest_reg, .o_first_operand_reg, .o_second_operand_reg, .o_const_valid,
        .o_const_value, .o_mem_req, .o_mem_load, .o_mem_addr, .o_mem_reg, .o_base_wr,
        .o_base_reg, .o_base_wdata);
    fpd_host_model i_host (.i_clk_sys, .i_resetn, .i_read_reg(i_insn[19:16]),
        .i_base_wr(o_base_wr), .i_base_reg(o_base_reg), .i_base_wdata(o_base_wdata),
        .o_base_value(i_base_value));

    always #12.5 i_clk_sys = ~i_clk_sys;

    // ----------------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------------
    task automatic finish_test();
        if (mismatches == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Offers one instruction and gathers every pulse until completion
    task automatic issue(input logic [31:0] insn, input logic cp);
        int n;
        nw = 0; trp = 0; dop = 0; bwr = 0;
        @(posedge i_clk_sys); #1;
        i_insn = insn; i_cond_pass = cp; i_valid = 1'h1;
        @(posedge i_clk_sys); #1;
        i_valid = 1'h0;
        for (n = 0; n < 40; n++) begin
            if (o_mem_req === 1'h1) begin
                if (nw < 16) begin
                    wa[nw] = o_mem_addr; wr[nw] = o_mem_reg; wl[nw] = o_mem_load;
                end
                nw++;
            end
            if (o_undef_trap === 1'h1) trp = 1'h1;
            if (o_data_op === 1'h1) dop = 1'h1;
            if (o_base_wr === 1'h1) begin
                bwr = 1'h1; bdat = o_base_wdata; breg = o_base_reg;
            end
            if (o_done === 1'h1) break;
            @(posedge i_clk_sys); #1;
        end
        if (n == 40) begin
            mismatches++;
            finish_test();
        end
    endtask : issue

    task automatic data_op(input logic [4:0] op, input logic [1:0] prec, input logic [1:0] rnd,
                           input logic ci, input logic [2:0] fm, input logic cp, input logic bd);
        issue({8'hee, op[4:1], prec[1], 3'h1, op[0], 3'h2, 4'h1, prec[0], rnd, 1'h0, ci, fm}, cp);
        chk(32'(trp), 32'(cp & bd));
        chk(32'(dop), 32'(cp & !bd));
        if (cp && !bd) begin
            chk(32'(o_opcode), 32'(op));
            chk(32'(o_dest_precision), 32'(prec));
            chk(32'(o_rounding_mode), 32'(rnd));
            chk({o_dest_reg, o_first_operand_reg, o_second_operand_reg}, {3'h2, 3'h1, fm});
            chk(32'(o_const_valid), 32'(ci));
            if (ci) chk(o_const_value, kval[fm]);
        end
    endtask : data_op

    task automatic multi(input logic l, input logic p, input logic u, input logic w,
                         input logic [1:0] cnt, input logic [2:0] fd, input logic [3:0] rn,
                         input logic [7:0] off, input logic [3:0] cop, input logic cp);
        logic [31:0] ob, wb, st;
        logic [2:0]  er;
        int          nr;
        nr = (cnt == 2'h0) ? 4 : int'(cnt);
        ob = {22'h0, off, 2'h0};
        wb = u ? base_m[rn] + ob : base_m[rn] - ob;
        st = (p || !u) ? wb : base_m[rn];
        issue({8'hec | {4'h0, 1'h0, 3'h0}, 4'h0, 20'h0} | {4'he, 3'h6, p, u, cnt[1], w, l, rn,
              cnt[0], fd, cop, off}, cp);
        chk(32'(trp), 32'(cp && cop != 4'h2));
        if (!cp || cop != 4'h2) begin
            chk(32'(nw) | 32'(bwr), 32'h0000_0000);
        end else begin
            chk(32'(nw), 32'(3 * nr));
            for (int k = 0; k < 3 * nr && k < 16; k++) begin
                er = fd + 3'(k / 3);
                chk(wa[k], st + 32'(4 * k));
                chk({wl[k], 28'h0, wr[k]}, {l, 28'h0, er});
            end
            chk(32'(bwr), 32'(w));
            if (w) begin
                chk(bdat, wb);
                chk(32'(breg), 32'(rn));
                base_m[rn] = wb;
            end
        end
    endtask : multi

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        i_clk_sys = 1'h0; i_resetn = 1'h0; i_valid = 1'h0; i_insn = 32'h0000_0000;
        i_cond_pass = 1'h1; mismatches = 0; check_count = 0;
        for (int k = 0; k < 16; k++) base_m[k] = 32'h0000_1000 + 32'(k) * 32'h0000_0100;
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_resetn = 1'h1;
        for (int k = 0; k < 17; k++) data_op(good[k], 2'(k % 3), 2'(k % 4), 1'h0, 3'(k), 1'h1,
                                             1'h0);
        for (int k = 0; k < 15; k++) data_op(bad[k], 2'h0, 2'h0, 1'h0, 3'h0, 1'h1, 1'h1);
        data_op(5'h00, 2'h3, 2'h0, 1'h0, 3'h0, 1'h1, 1'h1);
        for (int k = 0; k < 8; k++) data_op(5'h01, 2'h0, 2'h3, 1'h1, 3'(k), 1'h1, 1'h0);
        data_op(5'h00, 2'h0, 2'h0, 1'h0, 3'h0, 1'h0, 1'h0);
        // Only the two supported stack forms, never the program counter as base
        multi(1'h1, 1'h0, 1'h1, 1'h0, 2'h1, 3'h6, 4'h1, 8'h03, 4'h2, 1'h1);
        multi(1'h1, 1'h1, 1'h0, 1'h1, 2'h2, 3'h6, 4'h2, 8'h03, 4'h2, 1'h1);
        multi(1'h0, 1'h0, 1'h1, 1'h0, 2'h3, 3'h6, 4'h3, 8'h03, 4'h2, 1'h1);
        multi(1'h0, 1'h1, 1'h0, 1'h1, 2'h0, 3'h6, 4'h4, 8'h03, 4'h2, 1'h1);
        multi(1'h0, 1'h1, 1'h0, 1'h1, 2'h0, 3'h7, 4'h5, 8'hff, 4'h2, 1'h1);
        multi(1'h1, 1'h0, 1'h1, 1'h1, 2'h1, 3'h0, 4'h2, 8'h01, 4'h2, 1'h1);
        multi(1'h0, 1'h0, 1'h1, 1'h1, 2'h1, 3'h0, 4'h3, 8'h01, 4'h2, 1'h0);
        multi(1'h0, 1'h0, 1'h1, 1'h0, 2'h1, 3'h0, 4'h3, 8'h01, 4'h1, 1'h1);
        finish_test();
    end
endmodule : fpd_decoder_tb_top
